//--- rtl/otr_regs.svh
// register offsets, trigger fields, reset values and timing counts
`ifndef OTR_REGS_SVH
`define OTR_REGS_SVH

`define OTR_ADDR_W 7
`define OTR_TRIGGER_OFS 7'h0E
`define OTR_CODE_OFS 7'h10

`define OTR_OUT_CLEAR_BIT 9
`define OTR_ALARM_CLEAR_BIT 8
`define OTR_KEY_MSB 3
`define OTR_KEY_LSB 0
`define OTR_RESET_KEY 4'hA

`define OTR_TRIGGER_RESET 16'h0000
`define OTR_CODE_RESET 16'h0000

`define OTR_CLK_PERIOD_NS 10
`define OTR_UPDATE_NS 1000
`define OTR_UPDATE_CYCLES ((`OTR_UPDATE_NS + `OTR_CLK_PERIOD_NS - 1) / `OTR_CLK_PERIOD_NS)

`endif

//--- rtl/otr_pkg.sv
// types shared by the output code and trigger register bank
package otr_pkg;
	typedef enum logic [1:0] {
		OTR_IDLE = 2'b00,
		OTR_BUSY = 2'b01,
		OTR_LAST = 2'b11
	} otr_busy_state_t;
endpackage

//--- rtl/otr_busy_timer.sv
// update-busy window timer: high from a code load until the update time has passed
`timescale 1ns/10ps
`include "otr_regs.svh"

module otr_busy_timer import otr_pkg::*; #(
	parameter int UPDATE_CYCLES = `OTR_UPDATE_CYCLES
) (
	// clock and reset
	input wire logic sysClk,
	input wire logic rstSync_n,
	// control
	input wire logic start,
	input wire logic abort,
	// status
	output logic busy
);
	localparam int CW = $clog2(UPDATE_CYCLES + 1);

	otr_busy_state_t state;
	otr_busy_state_t next_state;
	logic [CW-1:0] count;

	always_comb begin
		next_state = state;
		case (state)
			OTR_IDLE: if (start) next_state = OTR_BUSY;
			OTR_BUSY: if (count <= CW'(2)) next_state = OTR_LAST;
			OTR_LAST: next_state = OTR_IDLE;
			default: next_state = OTR_IDLE;
		endcase
		if (abort) begin
			next_state = OTR_IDLE;
		end else if (start) begin
			next_state = (UPDATE_CYCLES == 1) ? OTR_LAST : OTR_BUSY;
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state <= OTR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// a new load restarts the window so the flag covers the latest update
	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count <= '0;
		end else if (abort) begin
			count <= '0;
		end else if (start) begin
			count <= CW'(UPDATE_CYCLES);
		end else if (count != '0) begin
			count <= count - CW'(1);
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			busy <= 1'b0;
		end else begin
			busy <= (next_state != OTR_IDLE);
		end
	end
endmodule

//--- rtl/otr_top.sv
// output code and action trigger registers of a single-channel converter
`timescale 1ns/10ps
`include "otr_regs.svh"

module otr_top import otr_pkg::*; #(
	parameter int RES_BITS = 16,
	parameter int UPDATE_CYCLES = `OTR_UPDATE_CYCLES
) (
	// clock and reset
	input wire logic sysClk,
	input wire logic rst_n,
	// register write port from the serial frame decoder
	input wire logic regWrite,
	input wire logic [`OTR_ADDR_W-1:0] regAddr,
	input wire logic [15:0] regData,
	// configuration and alarm sources
	input wire logic update_busy_flag_enable,
	input wire logic alarmEvent,
	// converter side
	output logic [15:0] outputCode,
	output logic codeLoad,
	output logic output_clear_strobe,
	output logic alarm_clear_strobe,
	output logic softResetPulse,
	// status
	output logic alarmLatched,
	output logic updateBusy,
	output logic fault
);
	////////////////////////////////////////////////////////////////////////////////
	// reset release
	// rst_n drops everything at once; release walks two flops so no flop leaves reset mid-edge

	logic rstMeta_n;
	logic rstSync_n;

	always_ff @(posedge sysClk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write decode

	function automatic logic addrHit(
		input logic wr,
		input logic [`OTR_ADDR_W-1:0] addr,
		input logic [`OTR_ADDR_W-1:0] ofs
	);
		addrHit = wr && (addr == ofs);
	endfunction

	// low bits below the resolution are don't-care and forced to zero
	localparam logic [15:0] CODE_MASK = 16'(~((32'h0000_0001 << (16 - RES_BITS)) - 1));

	logic trigWrite;
	logic codeWrite;
	logic keyHit;
	logic clrHit;
	logic almHit;
	logic loadHit;

	// trigger fields are decoded straight from the write; nothing is stored
	// unmapped offsets and reserved trigger bits decode to nothing
	always_comb begin
		trigWrite = addrHit(regWrite, regAddr, `OTR_TRIGGER_OFS);
		codeWrite = addrHit(regWrite, regAddr, `OTR_CODE_OFS);
		keyHit = trigWrite && (regData[`OTR_KEY_MSB:`OTR_KEY_LSB] == `OTR_RESET_KEY);
		clrHit = trigWrite && regData[`OTR_OUT_CLEAR_BIT];
		almHit = trigWrite && regData[`OTR_ALARM_CLEAR_BIT];
		// the key outranks every other action carried in the same word
		loadHit = !keyHit && (clrHit || codeWrite);
	end

	////////////////////////////////////////////////////////////////////////////////
	// action strobes, one flop each, never held beyond their cycle
	// a key in the same word suppresses the other two strobes

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			softResetPulse <= 1'b0;
		end else begin
			softResetPulse <= keyHit;
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			output_clear_strobe <= 1'b0;
		end else begin
			output_clear_strobe <= clrHit && !keyHit;
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			alarm_clear_strobe <= 1'b0;
		end else begin
			alarm_clear_strobe <= almHit && !keyHit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output code; no read path exists, the register is write-only

	logic [15:0] next_outputCode;

	always_comb begin
		next_outputCode = outputCode;
		if (keyHit) begin
			next_outputCode = `OTR_CODE_RESET;
		end else if (clrHit) begin
			next_outputCode = `OTR_CODE_RESET;
		end else if (codeWrite) begin
			next_outputCode = regData & CODE_MASK;
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			outputCode <= `OTR_CODE_RESET;
		end else begin
			outputCode <= next_outputCode;
		end
	end

	// a clear moves the output too, so it counts as an update
	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			codeLoad <= 1'b0;
		end else begin
			codeLoad <= loadHit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alarm latch: a new event in the clear cycle wins so it is never lost

	logic next_alarmLatched;

	always_comb begin
		next_alarmLatched = alarmLatched;
		if (alarmEvent) begin
			next_alarmLatched = 1'b1;
		end else if (keyHit || almHit) begin
			next_alarmLatched = 1'b0;
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			alarmLatched <= 1'b0;
		end else begin
			alarmLatched <= next_alarmLatched;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// update-busy window, untouched by alarm clear

	logic busyNow;
	logic busyShown;

	// a key write aborts the window; an output clear restarts it like a code load
	otr_busy_timer #(
		.UPDATE_CYCLES(UPDATE_CYCLES)
	) busyTimer (
		.sysClk(sysClk),
		.rstSync_n(rstSync_n),
		.start(loadHit),
		.abort(keyHit),
		.busy(busyNow)
	);

	// the enable only gates what is shown; the window itself always runs
	assign busyShown = busyNow && update_busy_flag_enable;

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			updateBusy <= 1'b0;
		end else begin
			updateBusy <= busyShown;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault pin

	// fault follows the latch directly and the busy window one cycle late
	// alarm clear has no path into the busy term, so the window survives it
	logic next_fault;

	always_comb begin
		next_fault = (alarmLatched && !(keyHit || almHit)) || alarmEvent;
		if (busyShown) begin
			next_fault = 1'b1;
		end
	end

	always_ff @(posedge sysClk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			fault <= 1'b0;
		end else begin
			fault <= next_fault;
		end
	end
endmodule

//--- testbench/otr_host_model.sv
// host model presenting one register write word at a time
`timescale 1ns/10ps
module otr_host_model (
	// clock
	input wire logic sysClk,
	// write word towards the block
	output logic regWrite,
	output logic [6:0] regAddr,
	output logic [15:0] regData
);
	initial begin
		regWrite = 1'b0;
		regAddr = 7'h00;
		regData = 16'h0000;
	end
	// idle lines carry the inverse so a stale word is never taken for a fresh one
	task automatic put(input logic [6:0] a, input logic [15:0] v, input logic [1:0] gap = 2'h0);
		repeat (gap) @(posedge sysClk);
		@(posedge sysClk);
		regWrite <= 1'b1;
		regAddr <= a;
		regData <= v;
		@(posedge sysClk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regData <= ~v;
		#1;
	endtask
endmodule

//--- testbench/otr_top_props.sv
// checker for the trigger and output code registers
`timescale 1ns/10ps
module otr_top_props #(
	parameter int RES_BITS = 16,
	parameter int UPDATE_CYCLES = 100
) (
	// clock and reset
	input wire logic sysClk,
	input wire logic rst_n,
	// register write port
	input wire logic regWrite,
	input wire logic [6:0] regAddr,
	input wire logic [15:0] regData,
	// configuration and alarm sources
	input wire logic update_busy_flag_enable,
	input wire logic alarmEvent,
	// converter side
	input wire logic [15:0] outputCode,
	input wire logic codeLoad,
	input wire logic output_clear_strobe,
	input wire logic alarm_clear_strobe,
	input wire logic softResetPulse,
	// status
	input wire logic alarmLatched,
	input wire logic updateBusy,
	input wire logic fault
);
	// cycles since the last load; the busy window must be over once this passes its length
	int quiet;
	always_ff @(posedge sysClk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 0;
		end else if (codeLoad) begin
			quiet <= 0;
		end else if (quiet < 1000) begin
			quiet <= quiet + 1;
		end
	end
	localparam logic [15:0] MASK = 16'hFFFF << (16 - RES_BITS);
	default clocking @(posedge sysClk); endclocking
	default disable iff (!rst_n);
	sequence trigWr; regWrite && regAddr == 7'h0E; endsequence
	sequence plainWr; trigWr ##0 regData[3:0] != 4'hA; endsequence
	AST_CLEAR: assert property (plainWr ##0 regData[9]
		|=> outputCode == 16'h0000 && output_clear_strobe) else $error("output not cleared");
	AST_KEEP: assert property (plainWr ##0 !regData[9]
		|=> $stable(outputCode) && !output_clear_strobe) else $error("output changed");
	AST_ALARM: assert property (plainWr ##0 (regData[8] && !alarmEvent)
		|=> alarm_clear_strobe && !alarmLatched) else $error("alarm not cleared");
	AST_SOFT: assert property (trigWr ##0 (regData[3:0] == 4'hA && !alarmEvent)
		|=> softResetPulse && outputCode == 16'h0000 && !alarmLatched ##1 !updateBusy)
		else $error("soft reset incomplete");
	AST_LOAD: assert property (regWrite && regAddr == 7'h10
		|=> codeLoad && outputCode == ($past(regData) & MASK)) else $error("bad code load");
	AST_BUSY: assert property (codeLoad && update_busy_flag_enable
		|=> fault && updateBusy) else $error("busy window missing");
	AST_DROP: assert property (quiet > UPDATE_CYCLES |-> !updateBusy)
		else $error("busy stuck");
	AST_STROBE: assert property (!(regWrite && regAddr == 7'h0E && regData[9])
		|=> !output_clear_strobe) else $error("strobe held");
endmodule
bind otr_top otr_top_props #(.RES_BITS(RES_BITS), .UPDATE_CYCLES(UPDATE_CYCLES)) otr_top_props_i (
	.sysClk(sysClk), .rst_n(rst_n), .regWrite(regWrite), .regAddr(regAddr), .regData(regData),
	.outputCode(outputCode), .update_busy_flag_enable(update_busy_flag_enable),
	.alarmEvent(alarmEvent), .codeLoad(codeLoad), .output_clear_strobe(output_clear_strobe),
	.alarm_clear_strobe(alarm_clear_strobe), .softResetPulse(softResetPulse),
	.alarmLatched(alarmLatched), .updateBusy(updateBusy), .fault(fault));

//--- testbench/otr_top_bench.sv
// self-checking bench of the trigger and output code registers
`timescale 1ns/10ps
module otr_top_bench;
	logic sysClk = 0, rst_n = 0, en = 0, alm = 0, regWrite, codeLoad, ocs, acs, srp, almL, busy, fault;
	logic [6:0] regAddr;
	logic [15:0] regData, outputCode, d, code16;
	int n_errors = 0, total_checks = 0, seed = 32'hb0e7;
	always #5 sysClk = ~sysClk;
	otr_host_model otr_host_model_i (.sysClk(sysClk), .regWrite(regWrite), .regAddr(regAddr),
		.regData(regData));
	otr_top #(.RES_BITS(12), .UPDATE_CYCLES(4)) otr_top_i (.sysClk(sysClk), .rst_n(rst_n),
		.regWrite(regWrite), .regAddr(regAddr), .regData(regData), .update_busy_flag_enable(en),
		.alarmEvent(alm), .outputCode(outputCode), .codeLoad(codeLoad), .output_clear_strobe(ocs),
		.alarm_clear_strobe(acs), .softResetPulse(srp), .alarmLatched(almL), .updateBusy(busy),
		.fault(fault));
	// full resolution copy on the same writes covers the 16-bit variant
	otr_top #(.RES_BITS(16), .UPDATE_CYCLES(4)) otr_top_full_i (.sysClk(sysClk), .rst_n(rst_n),
		.regWrite(regWrite), .regAddr(regAddr), .regData(regData), .update_busy_flag_enable(en),
		.alarmEvent(alm), .outputCode(code16), .codeLoad(), .output_clear_strobe(),
		.alarm_clear_strobe(), .softResetPulse(), .alarmLatched(), .updateBusy(), .fault());
	function logic [15:0] expCode(input logic [15:0] v);
		return v & 16'hFFF0;
	endfunction
	task chk(input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t mismatch", $time);
		end
	endtask
	task summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task pulseAlarm();
		@(posedge sysClk) alm <= 1'b1;
		@(posedge sysClk) alm <= 1'b0;
		#1 chk(almL === 1'b1 && fault === 1'b1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge sysClk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sysClk);
		for (int i = 0; i < 30; i++) begin
			d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h000F : 16'($random(seed));
			otr_host_model_i.put(7'h10, d, 2'($random(seed)));
			chk(outputCode === expCode(d) && code16 === d && codeLoad === 1'b1);
			otr_host_model_i.put(7'h11, ~d);
			chk(outputCode === expCode(d) && busy === 1'b0 && fault === 1'b0);
		end
		$display("code test done");
		pulseAlarm();
		otr_host_model_i.put(7'h0E, 16'h0100);
		chk(almL === 1'b0 && acs === 1'b1 && outputCode === expCode(d));
		otr_host_model_i.put(7'h0E, 16'h0200);
		chk(outputCode === 16'h0000 && ocs === 1'b1);
		@(posedge sysClk) #1 chk(ocs === 1'b0 && acs === 1'b0);
		$display("trigger test done");
		@(posedge sysClk) en <= 1'b1;
		repeat (6) @(posedge sysClk);
		#1 chk(busy === 1'b0 && fault === 1'b0);
		otr_host_model_i.put(7'h10, d);
		chk(codeLoad === 1'b1);
		@(posedge sysClk) #1 chk(fault === 1'b1 && busy === 1'b1 && codeLoad === 1'b0);
		otr_host_model_i.put(7'h0E, 16'h0100);
		chk(acs === 1'b1 && busy === 1'b1 && fault === 1'b1);
		@(posedge sysClk) #1 chk(busy === 1'b1 && fault === 1'b1);
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge sysClk) #1;
		if (busy !== 1'b0) begin
			n_errors++;
			summarize();
		end
		chk(fault === 1'b0);
		$display("busy test done");
		pulseAlarm();
		otr_host_model_i.put(7'h10, d);
		otr_host_model_i.put(7'h0E, {d[15:4], 4'hA});
		chk(srp === 1'b1 && outputCode === 16'h0000 && code16 === 16'h0000 && almL === 1'b0);
		@(posedge sysClk) #1 chk(srp === 1'b0 && busy === 1'b0 && fault === 1'b0);
		$display("reset test done");
		summarize();
	end
endmodule
